// file: logic/etp_pkg.sv
// Shared types and constants of the execution-time profiler.
package etp_pkg;

   // Measurement mode picked for the run.
   typedef enum logic [1:0] {
      ETP_RUN    = 2'b00,
      ETP_SINGLE = 2'b01,
      ETP_ACCUM  = 2'b10,
      ETP_DUAL   = 2'b11
   } etp_meas_t;

   // Profiling mode picked for the run.
   typedef enum logic [2:0] {
      ETP_EXCL = 3'b000,
      ETP_INCL = 3'b001,
      ETP_PAIR = 3'b010,
      ETP_AREA = 3'b011,
      ETP_NEST = 3'b100
   } etp_prof_t;

   // State of one interval timer.
   typedef enum logic {
      ETP_IV_WAIT   = 1'b0,
      ETP_IV_TIMING = 1'b1
   } etp_iv_t;

   localparam int ETP_CHANNELS = 8;
   localparam int ETP_SEL_W = 3;
   localparam int ETP_AW = 32;
   localparam int ETP_TW = 32;
   localparam int ETP_CW = 16;
   localparam int ETP_SW = 16;
   localparam logic [ETP_TW-1:0] ETP_TIME_RST = 32'h0000_0000;
   localparam logic [ETP_TW-1:0] ETP_MIN_RST = 32'hffff_ffff;
   localparam logic [ETP_CW-1:0] ETP_CNT_RST = 16'h0000;
   localparam logic [ETP_SW-1:0] ETP_STEP_ONE = 16'h0001;
   localparam logic [ETP_AW-1:0] ETP_ADDR_RST = 32'h0000_0000;

endpackage

// file: logic/etp_profiler.sv
// Execution-time measurement, interval timing and subroutine profiling.
//
// Function
// R01: Stepping halts after requested instruction count.
// R02: Stop address matches instruction first byte only.
// R03: Total time runs from launch to break.
// R04: Single interval: first cond two, break on one.
// R05: Interval modes disable program-counter breaks.
// R06: Accumulating interval sums, rearms, never stops.
// R07: Dual interval: two sums, no break.
// R08: Eight channels, four pairs in paired modes.
// R09: Count increments at end after start.
// R10: Exclusive time pauses during callee subroutines.
// R11: Inclusive time runs through callee subroutines.
// R12: Paired modes use fixed channel pairs.
// R13: Paired fetch times start range to end range.
// R14: Area mode counts data accesses in subroutine.
// R15: Nest mode counts child entries within parent.
// R16: Inclusive mode keeps largest and smallest duration.
// R17: Timeout stops run when limit exceeded.
// R18: Launch clears all timers and counters.
`timescale 1ns/1ps
module etp_profiler
   import etp_pkg::*;
(
   input logic clock_i,
   input logic rst_n_i,
   input logic run_start_i,
   input logic [ETP_AW-1:0] start_addr_i,
   input logic use_start_addr_i,
   input logic [ETP_AW-1:0] current_pc_i,
   input logic step_mode_i,
   input logic [ETP_SW-1:0] step_count_i,
   input logic step_stop_en_i,
   input logic [ETP_AW-1:0] step_stop_addr_i,
   input logic insn_done_i,
   input logic [ETP_AW-1:0] insn_addr_i,
   input etp_meas_t meas_mode_i,
   input etp_prof_t prof_mode_i,
   input logic bus_valid_i,
   input logic bus_fetch_i,
   input logic [ETP_AW-1:0] bus_addr_i,
   input logic hw_break_cond_one_i,
   input logic hw_break_cond_two_i,
   input logic hw_break_cond_three_i,
   input logic hw_break_cond_four_i,
   input logic pc_break_i,
   input logic ext_break_i,
   input logic [ETP_CHANNELS-1:0][ETP_AW-1:0] ch_lo_i,
   input logic [ETP_CHANNELS-1:0][ETP_AW-1:0] ch_hi_i,
   input logic [ETP_SEL_W-1:0] watch_sel_i,
   input logic timeout_en_i,
   input logic [ETP_TW-1:0] timeout_limit_i,
   output logic running_o,
   output logic stop_o,
   output logic [ETP_AW-1:0] step_pc_o,
   output logic [ETP_TW-1:0] total_time_o,
   output logic [ETP_TW-1:0] interval_a_o,
   output logic [ETP_TW-1:0] interval_b_o,
   output logic [ETP_CHANNELS-1:0][ETP_TW-1:0] prof_time_o,
   output logic [ETP_CHANNELS-1:0][ETP_CW-1:0] prof_count_o,
   output logic [ETP_TW-1:0] max_time_o,
   output logic [ETP_TW-1:0] min_time_o
);

   // The bus and break units run on this clock, so no synchronisers.
   logic running_r, running_nxt;
   logic stop_r, stop_nxt;
   logic [ETP_TW-1:0] total_r, total_nxt;
   logic [ETP_SW-1:0] step_left_r, step_left_nxt;
   logic [ETP_AW-1:0] step_pc_r, step_pc_nxt;
   etp_iv_t iv_a_r, iv_a_nxt, iv_b_r, iv_b_nxt;
   logic [ETP_TW-1:0] ia_r, ia_nxt, ib_r, ib_nxt;
   logic [ETP_TW-1:0] dur_r, dur_nxt, max_r, max_nxt, min_r, min_nxt;
   logic fetch, single_hit, step_hit, tmo_hit, pc_hit, stop_cause;
   logic [ETP_CHANNELS-1:0] in_rng, hit_lo, hit_hi;
   logic [ETP_CHANNELS-1:0] active_v, own_v, start_v, fin_v, tick_v;

   assign fetch = bus_valid_i & bus_fetch_i;

   // R01: stepping ends on the last requested instruction.
   // R02: only an instruction's first byte can equal the stop address.
   assign step_hit = step_mode_i & insn_done_i &
      ((step_left_r <= ETP_STEP_ONE) |
       (step_stop_en_i & (insn_addr_i == step_stop_addr_i)));

   // R05: program-counter breaks count only outside interval modes.
   assign pc_hit = pc_break_i & (meas_mode_i == ETP_RUN);

   // R04: the break comes from condition one after condition two.
   assign single_hit = (meas_mode_i == ETP_SINGLE) &
      (iv_a_r == ETP_IV_TIMING) & hw_break_cond_one_i;

   // R17: a duration beyond the limit stops the program.
   assign tmo_hit = timeout_en_i & active_v[watch_sel_i] &
      (dur_r > timeout_limit_i);

   assign stop_cause = running_r &
      (ext_break_i | pc_hit | single_hit | tmo_hit | step_hit);

   always_comb begin
      running_nxt = running_r;
      stop_nxt = 1'b0;
      total_nxt = total_r;
      step_left_nxt = step_left_r;
      step_pc_nxt = step_pc_r;
      if (run_start_i) begin
         // R18: a fresh launch starts every measurement from zero, the minimum from all ones.
         running_nxt = 1'b1;
         total_nxt = ETP_TIME_RST;
         step_left_nxt = step_count_i;
         // R01: start at the given address or else the current pc.
         step_pc_nxt = use_start_addr_i ? start_addr_i : current_pc_i;
      end else if (running_r) begin
         // R03: total time covers launch up to the stopping break.
         total_nxt = total_r + 32'h0000_0001;
         if (step_mode_i && insn_done_i) begin
            step_left_nxt = step_left_r - ETP_STEP_ONE;
         end
         if (stop_cause) begin
            running_nxt = 1'b0;
            stop_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         running_r <= 1'b0;
         stop_r <= 1'b0;
         total_r <= ETP_TIME_RST;
         step_left_r <= ETP_CNT_RST;
         step_pc_r <= ETP_ADDR_RST;
      end else begin
         running_r <= running_nxt;
         stop_r <= stop_nxt;
         total_r <= total_nxt;
         step_left_r <= step_left_nxt;
         step_pc_r <= step_pc_nxt;
      end
   end

   always_comb begin
      iv_a_nxt = iv_a_r;
      iv_b_nxt = iv_b_r;
      ia_nxt = ia_r;
      ib_nxt = ib_r;
      if (run_start_i) begin
         iv_a_nxt = ETP_IV_WAIT;
         iv_b_nxt = ETP_IV_WAIT;
         ia_nxt = ETP_TIME_RST;
         ib_nxt = ETP_TIME_RST;
      end else if (running_r && meas_mode_i != ETP_RUN) begin
         case (iv_a_r)
            ETP_IV_WAIT: begin
               // R04: timing opens on condition two.
               if (hw_break_cond_two_i) begin
                  iv_a_nxt = ETP_IV_TIMING;
               end
            end
            ETP_IV_TIMING: begin
               // R04: later condition-two matches do not restart.
               ia_nxt = ia_r + 32'h0000_0001;
               // R06: each closed interval adds up and rearms.
               if (hw_break_cond_one_i) begin
                  iv_a_nxt = ETP_IV_WAIT;
               end
            end
            default: iv_a_nxt = ETP_IV_WAIT;
         endcase
         // R07: second accumulator runs from condition four to three.
         if (meas_mode_i == ETP_DUAL) begin
            case (iv_b_r)
               ETP_IV_WAIT: begin
                  if (hw_break_cond_four_i) begin
                     iv_b_nxt = ETP_IV_TIMING;
                  end
               end
               ETP_IV_TIMING: begin
                  ib_nxt = ib_r + 32'h0000_0001;
                  if (hw_break_cond_three_i) begin
                     iv_b_nxt = ETP_IV_WAIT;
                  end
               end
               default: iv_b_nxt = ETP_IV_WAIT;
            endcase
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         iv_a_r <= ETP_IV_WAIT;
         iv_b_r <= ETP_IV_WAIT;
         ia_r <= ETP_TIME_RST;
         ib_r <= ETP_TIME_RST;
      end else begin
         iv_a_r <= iv_a_nxt;
         iv_b_r <= iv_b_nxt;
         ia_r <= ia_nxt;
         ib_r <= ib_nxt;
      end
   end

   // R08: eight channels; the paired modes see them as four pairs.
   for (genvar i = 0; i < ETP_CHANNELS; i++) begin : g_ch
      localparam int P = i ^ 1;
      localparam bit EVEN = (i % 2) == 0;
      logic active_r, active_nxt, own_r, own_nxt;
      logic start, fin, excl, extra;
      logic [ETP_TW-1:0] time_r, time_nxt;
      logic [ETP_CW-1:0] cnt_r, cnt_nxt;

      assign in_rng[i] = (bus_addr_i >= ch_lo_i[i]) &
         (bus_addr_i <= ch_hi_i[i]);
      assign hit_lo[i] = fetch & (bus_addr_i == ch_lo_i[i]);
      assign hit_hi[i] = fetch & (bus_addr_i == ch_hi_i[i]);

      always_comb begin
         start = 1'b0;
         fin = 1'b0;
         excl = 1'b0;
         extra = 1'b0;
         case (prof_mode_i)
            ETP_EXCL: begin
               start = hit_lo[i];
               fin = hit_hi[i];
               excl = 1'b1;
            end
            // R11: inclusive time ignores where the fetches go.
            ETP_INCL: begin
               start = hit_lo[i];
               fin = hit_hi[i];
            end
            // R12: the even channel is the start range, odd the end.
            // R13: a fetch in the start range opens the timing, one in the end range closes it.
            ETP_PAIR: begin
               if (EVEN) begin
                  start = fetch & in_rng[i];
                  fin = fetch & in_rng[P];
               end
            end
            // R14: data accesses made while the subroutine itself runs.
            ETP_AREA: begin
               if (EVEN) begin
                  start = hit_lo[i];
                  fin = hit_hi[i];
                  excl = 1'b1;
               end else begin
                  extra = bus_valid_i & ~bus_fetch_i & in_rng[i] &
                     active_v[P] & own_v[P];
               end
            end
            // R15: child entries seen while the parent is open.
            ETP_NEST: begin
               if (EVEN) begin
                  start = hit_lo[i];
                  fin = hit_hi[i];
                  excl = 1'b1;
               end else begin
                  extra = hit_lo[i] & active_v[P];
               end
            end
            default: ;
         endcase
      end

      assign start_v[i] = start & ~active_r;
      assign fin_v[i] = fin & active_r;
      // R10: exclusive time waits while fetches leave the own range.
      assign tick_v[i] = running_r & active_r & (~excl | own_r);
      assign active_v[i] = active_r;
      assign own_v[i] = own_r;

      always_comb begin
         active_nxt = active_r;
         own_nxt = fetch ? in_rng[i] : own_r;
         time_nxt = time_r;
         cnt_nxt = cnt_r;
         if (run_start_i) begin
            active_nxt = 1'b0;
            own_nxt = 1'b0;
            time_nxt = ETP_TIME_RST;
            cnt_nxt = ETP_CNT_RST;
         end else if (running_r) begin
            if (start_v[i]) begin
               active_nxt = 1'b1;
            end else if (fin_v[i]) begin
               active_nxt = 1'b0;
            end
            if (tick_v[i]) begin
               time_nxt = time_r + 32'h0000_0001;
            end
            // R09: one more pass counted at the end address.
            if (fin_v[i] || extra) begin
               cnt_nxt = cnt_r + 16'h0001;
            end
         end
      end

      always_ff @(posedge clock_i) begin
         if (!rst_n_i) begin
            active_r <= 1'b0;
            own_r <= 1'b0;
            time_r <= ETP_TIME_RST;
            cnt_r <= ETP_CNT_RST;
         end else begin
            active_r <= active_nxt;
            own_r <= own_nxt;
            time_r <= time_nxt;
            cnt_r <= cnt_nxt;
         end
      end

      assign prof_time_o[i] = time_r;
      assign prof_count_o[i] = cnt_r;
   end

   // One duration counter serves the watched channel; a trade of area
   // against watching all eight at once.
   always_comb begin
      dur_nxt = dur_r;
      max_nxt = max_r;
      min_nxt = min_r;
      if (run_start_i) begin
         dur_nxt = ETP_TIME_RST;
         max_nxt = ETP_TIME_RST;
         min_nxt = ETP_MIN_RST;
      end else if (running_r) begin
         if (start_v[watch_sel_i]) begin
            dur_nxt = ETP_TIME_RST;
         end else if (tick_v[watch_sel_i]) begin
            dur_nxt = dur_r + 32'h0000_0001;
         end
         // R16: inclusive runs keep the extreme single durations.
         // The closing cycle still ticks, so the extremes are taken from
         // the next duration and agree with the channel's own time.
         if (fin_v[watch_sel_i] && prof_mode_i == ETP_INCL) begin
            if (dur_nxt > max_r) begin
               max_nxt = dur_nxt;
            end
            if (dur_nxt < min_r) begin
               min_nxt = dur_nxt;
            end
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         dur_r <= ETP_TIME_RST;
         max_r <= ETP_TIME_RST;
         min_r <= ETP_MIN_RST;
      end else begin
         dur_r <= dur_nxt;
         max_r <= max_nxt;
         min_r <= min_nxt;
      end
   end

   assign running_o = running_r;
   assign stop_o = stop_r;
   assign step_pc_o = step_pc_r;
   assign total_time_o = total_r;
   assign interval_a_o = ia_r;
   assign interval_b_o = ib_r;
   assign max_time_o = max_r;
   assign min_time_o = min_r;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   a_step_halt: assert property (running_r && !run_start_i &&  // R01
      step_mode_i && insn_done_i && step_left_r == ETP_STEP_ONE
      |=> stop_o && !running_o)
      else $error("stepping did not halt at count");
   a_stop_addr: assert property (running_r && !run_start_i &&  // R02
      step_mode_i && step_stop_en_i && insn_done_i &&
      insn_addr_i == step_stop_addr_i |=> stop_o)
      else $error("stop address did not end stepping");
   a_total_run: assert property (running_r && !run_start_i  // R03
      |=> total_time_o == $past(total_time_o) + 32'h0000_0001)
      else $error("total time did not advance");
   a_single_brk: assert property (running_r && !run_start_i &&  // R04
      meas_mode_i == ETP_SINGLE && iv_a_r == ETP_IV_TIMING &&
      hw_break_cond_one_i |=> stop_o)
      else $error("single interval did not break");
   a_pc_masked: assert property (meas_mode_i != ETP_RUN &&  // R05
      !ext_break_i && !single_hit && !tmo_hit && !step_hit
      |=> !stop_o)
      else $error("stop while only pc break could cause it");
   // The closing cycle still adds one, so the total is held from the
   // cycle after the rearm onwards.
   a_accum_rearm: assert property (running_r && !run_start_i &&  // R06
      meas_mode_i == ETP_ACCUM && iv_a_r == ETP_IV_TIMING &&
      hw_break_cond_one_i ##1 !run_start_i
      |-> iv_a_r == ETP_IV_WAIT ##1 $stable(interval_a_o))
      else $error("accumulating interval did not rearm");
   a_excl_pause: assert property (running_r && !run_start_i &&  // R10
      prof_mode_i == ETP_EXCL && active_v[0] && !own_v[0]
      |=> $stable(prof_time_o[0]))
      else $error("exclusive time ran inside a callee");
   a_count_end: assert property (running_r && !run_start_i &&  // R09
      fin_v[0] |=> prof_count_o[0] == $past(prof_count_o[0]) + 16'h0001)
      else $error("pass count did not advance at end");
   a_timeout: assert property (running_r && !run_start_i && tmo_hit  // R17
      |=> stop_o ##1 !stop_o)
      else $error("timeout did not stop the run");
   a_launch_clr: assert property (run_start_i |=>  // R18
      total_time_o == 0 && interval_a_o == 0 &&
      prof_count_o[0] == 0 && min_time_o == '1)
      else $error("launch did not clear measurements");

   c_single: cover property (meas_mode_i == ETP_SINGLE && stop_o);
   c_dual: cover property (iv_b_r == ETP_IV_TIMING ##1
      iv_b_r == ETP_IV_WAIT);
   c_nest: cover property (prof_mode_i == ETP_NEST &&
      prof_count_o[1] != 0);
   c_minmax: cover property (max_r != 0 && min_r != ETP_MIN_RST);

endmodule

// file: verification/etp_bus_model.sv
// Behavioural model of the monitored processor bus and break units.
`timescale 1ns/1ps
module etp_bus_model
   import etp_pkg::*;
(
   input wire logic clock_i,
   output logic bus_valid_o,
   output logic bus_fetch_o,
   output logic [ETP_AW-1:0] bus_addr_o,
   output logic insn_done_o,
   output logic [ETP_AW-1:0] insn_addr_o,
   output logic [3:0] cond_o,
   output logic pc_break_o,
   output logic ext_break_o
);
   initial begin
      {ext_break_o, pc_break_o, insn_done_o, bus_fetch_o, bus_valid_o} = '0;
      cond_o = 4'h0;
      bus_addr_o = 32'h0000_0000;
      insn_addr_o = 32'h0000_0000;
   end

   // Kind bits: 8 other break, 7 pc break, 6 insn end, 5 fetch, 4 bus
   // cycle, 3..0 break unit matches. Each event is a one-cycle pulse.
   // Released address lines show the inverse of the last value, so a
   // design that samples them outside a pulse cannot see a stale match.
   task automatic ev(input logic [8:0] kind, input logic [ETP_AW-1:0] ad);
      @(posedge clock_i);
      {ext_break_o, pc_break_o, insn_done_o, bus_fetch_o, bus_valid_o,
       cond_o} <= kind;
      bus_addr_o <= ad;
      insn_addr_o <= ad;
      @(posedge clock_i);
      {ext_break_o, pc_break_o, insn_done_o, bus_fetch_o, bus_valid_o,
       cond_o} <= 9'h000;
      bus_addr_o <= ~ad;
      insn_addr_o <= ~ad;
   endtask
endmodule

// file: verification/tb.sv
// Self-checking bench for the execution-time profiler.
`timescale 1ns/1ps
module tb;
   import etp_pkg::*;
   localparam logic [8:0] F = 9'h030, D = 9'h010, I = 9'h040;
   localparam logic [8:0] P = 9'h080, X = 9'h100, C1 = 9'h001;
   localparam logic [8:0] C2 = 9'h002, C3 = 9'h004, C4 = 9'h008;
   localparam logic [ETP_AW-1:0] S = 32'h3000_0000, E = 32'h4000_0000;
   localparam logic [ETP_AW-1:0] CAL = 32'h9000_0000;
   logic clock_i, rst_n_i, run_start_i, use_start_addr_i, step_mode_i;
   logic step_stop_en_i, timeout_en_i, bus_valid_i, bus_fetch_i;
   logic insn_done_i, pc_break_i, ext_break_i, running_o, stop_o;
   logic [3:0] cond;
   logic [ETP_AW-1:0] start_addr_i, current_pc_i, step_stop_addr_i;
   logic [ETP_AW-1:0] insn_addr_i, bus_addr_i, step_pc_o, base, L;
   logic [ETP_SW-1:0] step_count_i;
   etp_meas_t meas_mode_i;
   etp_prof_t prof_mode_i;
   logic [ETP_CHANNELS-1:0][ETP_AW-1:0] ch_lo_i, ch_hi_i;
   logic [ETP_SEL_W-1:0] watch_sel_i;
   logic [ETP_TW-1:0] timeout_limit_i, total_time_o, interval_a_o;
   logic [ETP_TW-1:0] interval_b_o, max_time_o, min_time_o;
   logic [ETP_CHANNELS-1:0][ETP_TW-1:0] prof_time_o;
   logic [ETP_CHANNELS-1:0][ETP_CW-1:0] prof_count_o;
   int num_errors, n_tests, t0, a, b, c, r, k, n, own, sum;
   int dur [2];

   etp_profiler etp_profiler_inst (
      .clock_i, .rst_n_i, .run_start_i, .start_addr_i, .use_start_addr_i,
      .current_pc_i, .step_mode_i, .step_count_i, .step_stop_en_i,
      .step_stop_addr_i, .insn_done_i, .insn_addr_i, .meas_mode_i,
      .prof_mode_i, .bus_valid_i, .bus_fetch_i, .bus_addr_i,
      .hw_break_cond_one_i(cond[0]), .hw_break_cond_two_i(cond[1]),
      .hw_break_cond_three_i(cond[2]), .hw_break_cond_four_i(cond[3]),
      .pc_break_i, .ext_break_i, .ch_lo_i, .ch_hi_i, .watch_sel_i,
      .timeout_en_i, .timeout_limit_i, .running_o, .stop_o, .step_pc_o,
      .total_time_o, .interval_a_o, .interval_b_o, .prof_time_o,
      .prof_count_o, .max_time_o, .min_time_o);
   etp_bus_model etp_bus_model_inst (
      .clock_i, .bus_valid_o(bus_valid_i), .bus_fetch_o(bus_fetch_i),
      .bus_addr_o(bus_addr_i), .insn_done_o(insn_done_i),
      .insn_addr_o(insn_addr_i), .cond_o(cond), .pc_break_o(pc_break_i),
      .ext_break_o(ext_break_i));

   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   function automatic int t();
      return int'($time / 10);
   endfunction
   // A stop address on an instruction's first byte ends at the third step.
   function automatic int exp_steps(input int j, input int cnt);
      return (j != 0) ? 3 : cnt;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g, input int tol);
      n_tests++;
      if ($isunknown(g) || g > e + tol || g + tol < e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic ev(input logic [8:0] kind, input logic [ETP_AW-1:0] ad);
      etp_bus_model_inst.ev(kind, ad);
   endtask
   task automatic idle(input int cnt);
      repeat (cnt) @(posedge clock_i);
   endtask
   task automatic stops(input logic e);
      #1;
      chk("stop", e, stop_o, 0);
   endtask
   task automatic go(input etp_meas_t m, input etp_prof_t p, input logic st);
      @(posedge clock_i);
      meas_mode_i <= m;
      prof_mode_i <= p;
      step_mode_i <= st;
      run_start_i <= 1'b1;
      @(posedge clock_i);
      run_start_i <= 1'b0;
      t0 = t();
      #1;
      chk("running", 1, running_o, 0); // launch starts run
      chk("total", 0, total_time_o, 1); // launch clears
   endtask
   task automatic close_out();
      if (num_errors == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   initial begin
      #100000;
      num_errors++;
      close_out();
   end

   initial begin
      {rst_n_i, run_start_i, use_start_addr_i, step_mode_i} = '0;
      {step_stop_en_i, timeout_en_i} = '0;
      {start_addr_i, current_pc_i, step_stop_addr_i} = '0;
      step_count_i = 16'h0001;
      meas_mode_i = ETP_RUN;
      prof_mode_i = ETP_EXCL;
      {ch_lo_i, ch_hi_i} = '0;
      watch_sel_i = 3'h0;
      timeout_limit_i = 32'hffff_ffff;
      num_errors = 0;
      n_tests = 0;
      void'($urandom(52719));
      repeat (4) @(posedge clock_i);
      rst_n_i <= 1'b1;
      #1;
      chk("min_rst", ETP_MIN_RST, min_time_o, 0); // reset value
      go(ETP_RUN, ETP_EXCL, 1'b0);
      idle(5 + $urandom % 20);
      ev(X, 0);
      stops(1); // break ends run
      chk("total", t() - t0, total_time_o, 1); // elapsed time
      go(ETP_RUN, ETP_EXCL, 1'b0);
      ev(P, 0);
      stops(1); // honoured in run mode
      go(ETP_SINGLE, ETP_EXCL, 1'b0);
      ev(C1, 0);
      stops(0); // end before start
      ev(C2, 0);
      a = t();
      idle(3);
      ev(C2, 0);
      ev(P, 0);
      stops(0); // pc break ignored
      idle($urandom % 10);
      ev(C1, 0);
      b = t();
      stops(1); // break on end
      chk("single", b - a, interval_a_o, 2); // from first start
      go(ETP_ACCUM, ETP_EXCL, 1'b0);
      sum = 0;
      for (int q = 0; q < 3; q++) begin
         ev(C2, 0);
         a = t();
         idle(2 + $urandom % 8);
         ev(C1, 0);
         sum += t() - a;
         stops(0); // end does not stop
      end
      ev(P, 0);
      stops(0); // pc break ignored
      chk("accum", sum, interval_a_o, 6); // running total
      ev(X, 0);
      go(ETP_DUAL, ETP_EXCL, 1'b0);
      ev(C4, 0);
      a = t();
      ev(C2, 0);
      b = t();
      idle(4 + $urandom % 8);
      ev(C3, 0);
      c = t();
      ev(C1, 0);
      r = t();
      ev(P, 0);
      stops(0); // no break in dual
      chk("dual_b", c - a, interval_b_o, 2); // second pair
      chk("dual_a", r - b, interval_a_o, 2); // first pair
      ev(X, 0);
      for (int j = 0; j < 2; j++) begin
         @(posedge clock_i);
         base = 32'h1000_0000 + ($urandom % 4096) * 16;
         n = 5 + $urandom % 4;
         start_addr_i <= j ? base : ~base;
         current_pc_i <= j ? ~base : base;
         use_start_addr_i <= j[0];
         step_count_i <= 16'(n);
         step_stop_en_i <= 1'b1;
         step_stop_addr_i <= base + (j ? 4 : 1);
         go(ETP_RUN, ETP_EXCL, 1'b1);
         chk("step_pc", base, step_pc_o, 0); // start point
         for (k = 0; k < 12; k++) begin
            ev(I, base + 2 * k);
            #1;
            if (stop_o === 1'b1) break;
         end
         chk("steps", exp_steps(j, n), k + 1, 0); // step count
      end
      for (int p = 0; p < 2; p++) begin
         @(posedge clock_i);
         L = 32'h2000_0000 + ($urandom % 256) * 256;
         ch_lo_i[0] <= L;
         ch_hi_i[0] <= L + 32'h40;
         go(ETP_RUN, p ? ETP_INCL : ETP_EXCL, 1'b0);
         own = 0;
         for (int q = 0; q < 2; q++) begin
            ev(F, L);
            a = t();
            ev(F, L + 4);
            ev(F, CAL);
            c = t();
            idle(4 + 8 * q);
            ev(F, L + 8);
            r = t();
            ev(F, L + 32'h40);
            dur[q] = t() - a;
            own += dur[q] - (r - c);
         end
         #1;
         chk("count", 2, prof_count_o[0], 0); // passes counted
         chk("time", p ? dur[0] + dur[1] : own, prof_time_o[0], 4);
         if (p != 0) begin
            chk("max", dur[1], max_time_o, 0); // largest pass
            chk("min", dur[0], min_time_o, 0); // smallest pass
         end
         ev(X, 0);
      end
      @(posedge clock_i);
      n = 12 + $urandom % 8;
      timeout_en_i <= 1'b1;
      timeout_limit_i <= 32'(n);
      go(ETP_RUN, ETP_INCL, 1'b0);
      ev(F, L);
      a = t();
      for (k = 0; k < 60; k++) begin
         @(posedge clock_i);
         #1;
         if (stop_o === 1'b1) break;
      end
      chk("timeout", n + 2, t() - a, 2); // stop past limit
      @(posedge clock_i);
      timeout_en_i <= 1'b0;
      {ch_lo_i[2], ch_hi_i[2], ch_lo_i[3], ch_hi_i[3]} <=
         {S, S + 32'h40, E, E + 32'h40};
      go(ETP_RUN, ETP_PAIR, 1'b0);
      ev(F, S + 8);
      a = t();
      ev(F, CAL);
      idle(3);
      ev(F, E + 4);
      b = t();
      #1;
      chk("pair_cnt", 1, prof_count_o[2], 0); // even slot of pair
      chk("pair_time", b - a, prof_time_o[2], 2); // start to end range
      ev(X, 0);
      go(ETP_RUN, ETP_AREA, 1'b0);
      ev(D, E);
      ev(F, S);
      ev(D, E + 4);
      ev(F, CAL);
      ev(D, E + 8);
      ev(F, S + 4);
      ev(D, E + 32'h40);
      ev(F, S + 32'h40);
      #1;
      chk("area", 2, prof_count_o[3], 0); // accesses in subroutine
      ev(X, 0);
      go(ETP_RUN, ETP_NEST, 1'b0);
      ev(F, E);
      ev(F, E + 32'h40);
      for (int q = 0; q < 2; q++) begin
         ev(F, S + 4 * q);
         ev(F, E);
         ev(F, E + 32'h40);
      end
      ev(F, S + 32'h40);
      #1;
      chk("nest", 2, prof_count_o[3], 0); // child entries in parent
      close_out();
   end
endmodule
